/* File: tmc_pkg.sv */
// Shared constants and types for the tape mode change control block
package tmc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and tape time
	localparam int CLK_PERIOD_NS = 8;
	// Mode change to aux output spans two segments
	localparam int PR_START_DELAY_US = 85300;
	localparam int SEG_CYCLES_DEF = (PR_START_DELAY_US * 1000) / (2 * CLK_PERIOD_NS);
	localparam int URD_HOLD_SEGS = 5;
	localparam int RR_SEG3_ENDS = 2;
	localparam int AUX_EXPECT_FROM = 3;
	localparam int AUX_EXPECT_TO = 5;

	////////////////////////////////////////////////////////////////////////////////
	// Time segment numbers
	localparam logic [1:0] SEG_0 = 2'h0;
	localparam logic [1:0] SEG_2 = 2'h2;
	localparam logic [1:0] SEG_3 = 2'h3;

	////////////////////////////////////////////////////////////////////////////////
	// Mode codes on the request and status ports
	localparam logic [1:0] MODE_PLAY_PLAY = 2'h0;
	localparam logic [1:0] MODE_REC_REC = 2'h1;
	localparam logic [1:0] MODE_PLAY_REC = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Scratch pad counter layout
	localparam logic [1:0] QUARTER_LOW = 2'h0;
	localparam int CP_PAGE_LSB = 4;
	localparam int CP_COL_LSB = 1;
	localparam int CP_ROW8_BIT = 0;
	localparam int RB_MARK_BIT = 7;
	localparam logic [6:0] CP_RESET = 7'h01;
	localparam logic [7:0] RB_RESET = 8'h80;

	////////////////////////////////////////////////////////////////////////////////
	// Controller states
	typedef enum logic [6:0] {
		ST_PP = 7'h01,
		ST_PP2RR = 7'h02,
		ST_PP2PR = 7'h04,
		ST_RR = 7'h08,
		ST_RR2PP = 7'h10,
		ST_PR = 7'h20,
		ST_PR2PP = 7'h40
	} tmc_state_e;

endpackage

/* File: tmc_seg_timer.sv */
// Tape time segment counter
`timescale 1ns/1ps
`default_nettype none
module tmc_seg_timer #(
	parameter int SEG_CYCLES = tmc_pkg::SEG_CYCLES_DEF
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic clear_in,
	output logic seg_end_out,
	output logic [1:0] seg_num_out
);
	localparam int CW = $clog2(SEG_CYCLES + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic [1:0] seg;
	} tmc_timer_s;

	tmc_timer_s state_reg;
	tmc_timer_s state_next;

	////////////////////////////////////////////////////////////////////////////////
	assign seg_end_out = (state_reg.cnt == CW'(SEG_CYCLES - 1));
	assign seg_num_out = state_reg.seg;

	always_comb begin
		state_next = state_reg;
		// Clear beats the segment end so the jump lands on segment 0
		if (clear_in) begin
			state_next.cnt = '0;
			state_next.seg = tmc_pkg::SEG_0;
		end else if (seg_end_out) begin
			state_next.cnt = '0;
			state_next.seg = state_reg.seg + 2'h1;
		end else begin
			state_next.cnt = state_reg.cnt + CW'(1);
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= '0;
		end else if (ce_in) begin
			state_reg <= state_next;
		end
	end
endmodule // tmc_seg_timer
`default_nettype wire

/* File: tmc_scratch_addr.sv */
// Scratch pad address counters
`timescale 1ns/1ps
`default_nettype none
module tmc_scratch_addr (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic load_in,
	input wire logic inc_in,
	input wire logic [1:0] ram_quarter_select_in,
	input wire logic [2:0] page_in,
	input wire logic [2:0] column_in,
	input wire logic [8:0] row_in,
	output logic [6:0] scratch_column_page_counter_out,
	output logic [7:0] scratch_row_byte_counter_out
);
	typedef struct packed {
		logic [1:0] quarter;
		logic [6:0] cp;
		logic [7:0] rb;
	} tmc_addr_s;

	tmc_addr_s state_reg;
	tmc_addr_s state_next;
	logic [8:0] row_wide;

	assign scratch_column_page_counter_out = state_reg.cp;
	assign scratch_row_byte_counter_out = state_reg.rb;
	assign row_wide = {state_reg.cp[tmc_pkg::CP_ROW8_BIT], state_reg.rb} + 9'h001;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		if (load_in) begin
			state_next.quarter = ram_quarter_select_in;
			state_next.cp = {page_in, column_in, 1'b1};
			if (ram_quarter_select_in == tmc_pkg::QUARTER_LOW) begin
				state_next.rb = {1'b1, row_in[6:0]};
			end else begin
				state_next.cp[tmc_pkg::CP_ROW8_BIT] = row_in[8];
				state_next.rb = row_in[7:0];
			end
		end else if (inc_in) begin
			if (state_reg.quarter == tmc_pkg::QUARTER_LOW) begin
				state_next.rb = {1'b1, state_reg.rb[6:0] + 7'h01};
			end else begin
				state_next.cp[tmc_pkg::CP_ROW8_BIT] = row_wide[8];
				state_next.rb = row_wide[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= {tmc_pkg::QUARTER_LOW, tmc_pkg::CP_RESET, tmc_pkg::RB_RESET};
		end else if (ce_in) begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	property p_low_layout;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && load_in && ram_quarter_select_in == tmc_pkg::QUARTER_LOW |=>
			scratch_row_byte_counter_out[tmc_pkg::RB_MARK_BIT] && scratch_column_page_counter_out[0]
			&& scratch_row_byte_counter_out[6:0] == 7'($past(row_in));
	endproperty
	a_low_layout: assert property (p_low_layout) else $error("low quarter layout wrong");

	property p_high_layout;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && load_in && ram_quarter_select_in != tmc_pkg::QUARTER_LOW |=>
			{scratch_column_page_counter_out[0], scratch_row_byte_counter_out} == $past(row_in)
			&& scratch_column_page_counter_out[6:1] == {$past(page_in), $past(column_in)};
	endproperty
	a_high_layout: assert property (p_high_layout) else $error("upper quarter layout wrong");
endmodule // tmc_scratch_addr
`default_nettype wire

/* File: tmc_mode_ctrl.sv */
// Tape format engine mode change controller, top level
`timescale 1ns/1ps
`default_nettype none
module tmc_mode_ctrl #(
	parameter int SEG_CYCLES = tmc_pkg::SEG_CYCLES_DEF
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic mode_req_valid_in,
	input wire logic [1:0] mode_req_in,
	input wire logic search_exit_in,
	input wire logic scratch_load_in,
	input wire logic scratch_inc_in,
	input wire logic [1:0] ram_quarter_select_in,
	input wire logic [2:0] scratch_page_in,
	input wire logic [2:0] scratch_column_in,
	input wire logic [8:0] scratch_row_in,
	output logic [1:0] mode_out,
	output logic mode_change_pending_out,
	output logic req_ignored_out,
	output logic write_main_out,
	output logic write_aux_out,
	output logic unreliable_data_flag_out,
	output logic aux_read_expect_out,
	output logic seg_end_out,
	output logic [1:0] seg_num_out,
	output logic [6:0] scratch_column_page_counter_out,
	output logic [7:0] scratch_row_byte_counter_out
);
	typedef struct packed {
		tmc_pkg::tmc_state_e st;
		logic ign;
		logic wr_main;
		logic wr_aux;
		logic [1:0] seg3_ends;
		logic urd;
		logic urd_act;
		logic [2:0] urd_cnt;
		logic aux_track;
		logic [2:0] aux_cnt;
		logic aux_exp;
	} tmc_ctrl_s;

	tmc_ctrl_s state_reg;
	tmc_ctrl_s state_next;
	logic seg_end;
	logic [1:0] seg_num;
	logic seg_clear;
	logic seg0_end;
	logic seg2_end;
	logic seg3_end;
	logic in_rr;
	logic in_pr;

	////////////////////////////////////////////////////////////////////////////////
	// Time base and scratch pad addressing
	tmc_seg_timer #(
		.SEG_CYCLES(SEG_CYCLES)
	) u_timer (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.clear_in(seg_clear),
		.seg_end_out(seg_end),
		.seg_num_out(seg_num)
	);

	tmc_scratch_addr u_addr (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.load_in(scratch_load_in),
		.inc_in(scratch_inc_in),
		.ram_quarter_select_in(ram_quarter_select_in),
		.page_in(scratch_page_in),
		.column_in(scratch_column_in),
		.row_in(scratch_row_in),
		.scratch_column_page_counter_out(scratch_column_page_counter_out),
		.scratch_row_byte_counter_out(scratch_row_byte_counter_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Segment edge decode
	assign seg0_end = seg_end && seg_num == tmc_pkg::SEG_0;
	assign seg2_end = seg_end && seg_num == tmc_pkg::SEG_2;
	assign seg3_end = seg_end && seg_num == tmc_pkg::SEG_3;
	assign in_rr = state_reg.st == tmc_pkg::ST_RR || state_reg.st == tmc_pkg::ST_RR2PP;
	assign in_pr = state_reg.st == tmc_pkg::ST_PR || state_reg.st == tmc_pkg::ST_PR2PP;
	// Only the record/record exit restarts the segment count
	assign seg_clear = state_reg.st == tmc_pkg::ST_RR2PP && seg0_end;

	assign seg_end_out = seg_end;
	assign seg_num_out = seg_num;
	assign write_main_out = state_reg.wr_main;
	assign write_aux_out = state_reg.wr_aux;
	assign unreliable_data_flag_out = state_reg.urd;
	assign aux_read_expect_out = state_reg.aux_exp;
	assign req_ignored_out = state_reg.ign;
	assign mode_change_pending_out = state_reg.st == tmc_pkg::ST_PP2RR
		|| state_reg.st == tmc_pkg::ST_PP2PR || state_reg.st == tmc_pkg::ST_RR2PP
		|| state_reg.st == tmc_pkg::ST_PR2PP;

	always_comb begin
		case (state_reg.st)
			tmc_pkg::ST_RR, tmc_pkg::ST_RR2PP: begin
				mode_out = tmc_pkg::MODE_REC_REC;
			end
			tmc_pkg::ST_PR, tmc_pkg::ST_PR2PP: begin
				mode_out = tmc_pkg::MODE_PLAY_REC;
			end
			default: begin
				mode_out = tmc_pkg::MODE_PLAY_PLAY;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		state_next = state_reg;
		state_next.ign = 1'b0;

		if (in_rr && !state_reg.wr_main) begin
			if (seg3_end && state_reg.seg3_ends != 2'(tmc_pkg::RR_SEG3_ENDS)) begin
				state_next.seg3_ends = state_reg.seg3_ends + 2'h1;
			end else if (seg0_end && state_reg.seg3_ends == 2'(tmc_pkg::RR_SEG3_ENDS)) begin
				state_next.wr_main = 1'b1;
				state_next.wr_aux = 1'b1;
			end
		end
		// aux output at next segment 1
		if (in_pr && !state_reg.wr_aux && seg0_end) begin
			state_next.wr_aux = 1'b1;
		end

		if (state_reg.urd_act && seg_end) begin
			state_next.urd_cnt = state_reg.urd_cnt + 3'h1;
			if (state_reg.urd_cnt == 3'(tmc_pkg::URD_HOLD_SEGS - 1)) begin
				state_next.urd = 1'b0;
				state_next.urd_act = 1'b0;
			end
		end
		if (search_exit_in) begin
			state_next.urd = 1'b1;
			state_next.urd_act = 1'b1;
			state_next.urd_cnt = '0;
		end

		if (state_reg.aux_track && seg_end) begin
			state_next.aux_cnt = state_reg.aux_cnt + 3'h1;
			if (state_reg.aux_cnt == 3'(tmc_pkg::AUX_EXPECT_FROM - 1)) begin
				state_next.aux_exp = 1'b1;
			end
			if (state_reg.aux_cnt == 3'(tmc_pkg::AUX_EXPECT_TO - 1)) begin
				state_next.aux_exp = 1'b0;
				state_next.aux_track = 1'b0;
			end
		end

		case (state_reg.st)
			tmc_pkg::ST_PP: begin
				if (mode_req_valid_in) begin
					if (mode_req_in == tmc_pkg::MODE_REC_REC) begin
						state_next.st = tmc_pkg::ST_PP2RR;
					end else if (mode_req_in == tmc_pkg::MODE_PLAY_REC) begin
						state_next.st = tmc_pkg::ST_PP2PR;
						state_next.aux_track = 1'b0;
						state_next.aux_exp = 1'b0;
					end else begin
						state_next.ign = 1'b1;
					end
				end
			end
			// apply at end of current segment
			tmc_pkg::ST_PP2RR: begin
				if (seg_end) begin
					state_next.st = tmc_pkg::ST_RR;
					state_next.seg3_ends = '0;
				end
			end
			// apply at end of segment 2
			tmc_pkg::ST_PP2PR: begin
				if (seg2_end) begin
					state_next.st = tmc_pkg::ST_PR;
				end
			end
			tmc_pkg::ST_RR: begin
				if (mode_req_valid_in) begin
					if (mode_req_in == tmc_pkg::MODE_PLAY_PLAY) begin
						state_next.st = tmc_pkg::ST_RR2PP;
					end else begin
						state_next.ign = 1'b1;
					end
				end
			end
			tmc_pkg::ST_RR2PP: begin
				if (seg0_end) begin
					state_next.st = tmc_pkg::ST_PP;
					state_next.wr_main = 1'b0;
					state_next.wr_aux = 1'b0;
					state_next.urd = 1'b1;
					state_next.urd_act = 1'b1;
					state_next.urd_cnt = '0;
				end
			end
			tmc_pkg::ST_PR: begin
				if (mode_req_valid_in) begin
					if (mode_req_in == tmc_pkg::MODE_PLAY_PLAY) begin
						state_next.st = tmc_pkg::ST_PR2PP;
					end else begin
						state_next.ign = 1'b1;
					end
				end
			end
			// aux stop at end of segment 0
			tmc_pkg::ST_PR2PP: begin
				if (seg0_end) begin
					state_next.st = tmc_pkg::ST_PP;
					state_next.wr_aux = 1'b0;
					state_next.aux_track = 1'b1;
					state_next.aux_cnt = '0;
					state_next.aux_exp = 1'b0;
				end
			end
			default: begin
				state_next.st = tmc_pkg::ST_PP;
			end
		endcase

		// Requests during a pending change are refused
		if (mode_req_valid_in && mode_change_pending_out) begin
			state_next.ign = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= '{st: tmc_pkg::ST_PP, default: '0};
		end else if (ce_in) begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	logic seg0_end_q;
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			seg0_end_q <= 1'b0;
		end else if (ce_in) begin
			seg0_end_q <= seg0_end;
		end
	end

	property p_no_rec_swap;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && state_reg.st == tmc_pkg::ST_RR && mode_req_valid_in && mode_req_in == tmc_pkg::MODE_PLAY_REC
			|=> mode_out == tmc_pkg::MODE_REC_REC && req_ignored_out;
	endproperty
	a_no_rec_swap: assert property (p_no_rec_swap) else $error("record swap not refused");

	property p_rr_apply;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && state_reg.st == tmc_pkg::ST_PP2RR && seg_end |=> mode_out == tmc_pkg::MODE_REC_REC;
	endproperty
	a_rr_apply: assert property (p_rr_apply) else $error("record mode not applied");

	property p_rr_write_start;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		$rose(write_main_out) |-> seg0_end_q && write_aux_out && mode_out == tmc_pkg::MODE_REC_REC;
	endproperty
	a_rr_write_start: assert property (p_rr_write_start) else $error("write start misplaced");

	property p_pr_wait;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && state_reg.st == tmc_pkg::ST_PP2PR && !seg2_end |=> mode_out == tmc_pkg::MODE_PLAY_PLAY;
	endproperty
	a_pr_wait: assert property (p_pr_wait) else $error("play record applied early");

	property p_rr_exit;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && state_reg.st == tmc_pkg::ST_RR2PP && seg0_end
			|=> seg_num_out == tmc_pkg::SEG_0 && !write_main_out && !write_aux_out && unreliable_data_flag_out;
	endproperty
	a_rr_exit: assert property (p_rr_exit) else $error("record exit wrong");

	property p_urd_hold;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		$fell(unreliable_data_flag_out) |-> $past(state_reg.urd_cnt) == 3'(tmc_pkg::URD_HOLD_SEGS - 1);
	endproperty
	a_urd_hold: assert property (p_urd_hold) else $error("flag hold length wrong");

	property p_pr_exit;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && state_reg.st == tmc_pkg::ST_PR2PP && seg0_end
			|=> !write_aux_out && mode_out == tmc_pkg::MODE_PLAY_PLAY;
	endproperty
	a_pr_exit: assert property (p_pr_exit) else $error("aux write not stopped");

	property p_search_exit;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && search_exit_in |=> unreliable_data_flag_out;
	endproperty
	a_search_exit: assert property (p_search_exit) else $error("flag not raised");

	property p_aux_window;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		$rose(aux_read_expect_out) |-> mode_out == tmc_pkg::MODE_PLAY_PLAY && seg_num_out == tmc_pkg::SEG_0;
	endproperty
	a_aux_window: assert property (p_aux_window) else $error("aux window misplaced");

	property p_ignored_stays;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		ce_in && state_reg.st == tmc_pkg::ST_PR && mode_req_valid_in && mode_req_in == tmc_pkg::MODE_REC_REC
			|=> mode_out == tmc_pkg::MODE_PLAY_REC;
	endproperty
	a_ignored_stays: assert property (p_ignored_stays) else $error("refused request changed mode");

	c_rr_write: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) $rose(write_main_out));
	c_pr_write: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		$rose(write_aux_out) && mode_out == tmc_pkg::MODE_PLAY_REC);
	c_urd_fall: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) $fell(unreliable_data_flag_out));
	c_aux_exp: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) $fell(aux_read_expect_out));
endmodule // tmc_mode_ctrl
`default_nettype wire

/* File: tmc_uc_model.sv */
// Microcontroller model that drives the mode change controller
`timescale 1ns/1ps
`default_nettype none
module tmc_uc_model (
	input wire logic ref_clk_in,
	output logic mode_req_valid_out,
	output logic [1:0] mode_req_out,
	output logic search_exit_out,
	output logic scratch_load_out,
	output logic scratch_inc_out,
	output logic [1:0] ram_quarter_select_out,
	output logic [2:0] scratch_page_out,
	output logic [2:0] scratch_column_out,
	output logic [8:0] scratch_row_out
);
	logic eq_search;
	logic irq_enabled;
	initial begin
		mode_req_valid_out = 1'h0;
		mode_req_out = 2'h0;
		search_exit_out = 1'h0;
		scratch_load_out = 1'h0;
		scratch_inc_out = 1'h0;
		ram_quarter_select_out = 2'h0;
		scratch_page_out = 3'h0;
		scratch_column_out = 3'h0;
		scratch_row_out = 9'h000;
		eq_search = 1'h0;
		irq_enabled = 1'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic send_mode(input logic [1:0] code);
		@(posedge ref_clk_in);
		mode_req_valid_out <= 1'h1;
		mode_req_out <= code;
		@(posedge ref_clk_in);
		mode_req_valid_out <= 1'h0;
		// Idle code lines carry garbage, never the last value
		mode_req_out <= ~code;
		@(negedge ref_clk_in);
	endtask
	task automatic search_enter();
		@(posedge ref_clk_in);
		eq_search <= 1'h1;
		@(posedge ref_clk_in);
		irq_enabled <= 1'h1;
		@(negedge ref_clk_in);
	endtask
	task automatic search_leave();
		@(posedge ref_clk_in);
		irq_enabled <= 1'h0;
		@(posedge ref_clk_in);
		eq_search <= 1'h0;
		search_exit_out <= 1'h1;
		@(posedge ref_clk_in);
		search_exit_out <= 1'h0;
		@(negedge ref_clk_in);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic load_addr(input logic [1:0] q, input logic [2:0] p, input logic [2:0] c, input logic [8:0] r);
		@(posedge ref_clk_in);
		scratch_load_out <= 1'h1;
		ram_quarter_select_out <= q;
		scratch_page_out <= p;
		scratch_column_out <= c;
		scratch_row_out <= r;
		@(posedge ref_clk_in);
		scratch_load_out <= 1'h0;
		scratch_page_out <= ~p;
		scratch_column_out <= ~c;
		scratch_row_out <= ~r;
		@(negedge ref_clk_in);
	endtask
	task automatic inc_row();
		@(posedge ref_clk_in);
		scratch_inc_out <= 1'h1;
		@(posedge ref_clk_in);
		scratch_inc_out <= 1'h0;
		@(negedge ref_clk_in);
	endtask
endmodule // tmc_uc_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the mode change controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin n_fail++; $display("FAIL %0t %s", $time, msg); end end
module testbench;
	localparam int SEG = 16;
	logic ref_clk_in;
	logic rst_n_in;
	logic ce_in;
	logic vld, srch, ld, inc, pend, ign, wmain, waux, urd, aexp, send;
	logic [1:0] req, qsel, mode, snum;
	logic [2:0] pg, col;
	logic [8:0] row;
	logic [6:0] cp;
	logic [7:0] rb;
	int n_fail = 0;
	int comparisons = 0;
	int mode_m, seg_m, tgt_m, last_seg;
	logic ign_m;

	tmc_uc_model u (.ref_clk_in(ref_clk_in), .mode_req_valid_out(vld), .mode_req_out(req), .search_exit_out(srch),
		.scratch_load_out(ld), .scratch_inc_out(inc), .ram_quarter_select_out(qsel), .scratch_page_out(pg),
		.scratch_column_out(col), .scratch_row_out(row));
	tmc_mode_ctrl #(.SEG_CYCLES(SEG)) dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
		.mode_req_valid_in(vld), .mode_req_in(req), .search_exit_in(srch), .scratch_load_in(ld),
		.scratch_inc_in(inc), .ram_quarter_select_in(qsel), .scratch_page_in(pg), .scratch_column_in(col),
		.scratch_row_in(row), .mode_out(mode), .mode_change_pending_out(pend), .req_ignored_out(ign),
		.write_main_out(wmain), .write_aux_out(waux), .unreliable_data_flag_out(urd),
		.aux_read_expect_out(aexp), .seg_end_out(send), .seg_num_out(snum),
		.scratch_column_page_counter_out(cp), .scratch_row_byte_counter_out(rb));

	initial begin
		ref_clk_in = 1'h0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end

	function automatic bit allowed(int cur, int nw);
		return nw != cur && nw < 3 && (cur == 0 || nw == 0);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Reference model: applied mode, pending target, segment number
	always @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_m <= 0;
			seg_m <= 0;
			tgt_m <= -1;
			ign_m <= 1'h0;
		end else if (ce_in) begin
			ign_m <= vld && !(tgt_m < 0 && allowed(mode_m, req));
			if (vld && tgt_m < 0 && allowed(mode_m, req))
				tgt_m <= req;
			if (send) begin
				seg_m <= (seg_m + 1) % 4;
				if (tgt_m == 1 || (tgt_m == 2 && seg_m == 2) || (tgt_m == 0 && seg_m == 0)) begin
					mode_m <= tgt_m;
					tgt_m <= -1;
					if (mode_m == 1)
						seg_m <= 0;
				end
			end
		end
	end

	always @(negedge ref_clk_in) begin
		if (rst_n_in) begin
			`CHK(mode, 2'(mode_m), "mode")
			`CHK(snum, 2'(seg_m), "segment number")
			`CHK(pend, tgt_m >= 0, "pending")
			`CHK(ign, ign_m, "ignored pulse")
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic wend();
		int k;
		k = 0;
		while (send !== 1'h1 && k < 4 * SEG) begin
			@(negedge ref_clk_in);
			k++;
		end
		`CHK(send, 1'h1, "segment end")
		last_seg = snum;
		@(negedge ref_clk_in);
	endtask
	task automatic wend_at(int s);
		int k;
		k = 0;
		do begin
			wend();
			k++;
		end while (last_seg != s && k < 6);
	endtask
	task automatic flag_hold();
		for (int i = 1; i <= 5; i++) begin
			wend();
			`CHK(urd, i < 5, "flag hold")
		end
	endtask
	task automatic tend(string name);
		$display("test %s done", name);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#100000;
		n_fail++;
		$display("FAIL %0t watchdog expired", $time);
		stop_test();
	end

	initial begin
		int n, q, p, c, r, cpe, rbe, v;
		void'($urandom(32'h4CB8DD5A));
		rst_n_in = 1'h0;
		ce_in = 1'h1;
		repeat (20) @(negedge ref_clk_in);
		`CHK({cp, rb}, {7'h01, 8'h80}, "counter reset")
		`CHK({wmain, waux, urd, aexp}, 4'h0, "flag reset")
		@(posedge ref_clk_in);
		rst_n_in <= 1'h1;
		@(negedge ref_clk_in);
		u.send_mode(2'h0);
		u.send_mode(2'h3);
		tend("refused");
		for (n = 0; n < 4 * SEG && snum !== 2'h2; n++)
			@(negedge ref_clk_in);
		u.send_mode(2'h1);
		u.send_mode(2'h2);
		wend();
		u.send_mode(2'h2);
		u.send_mode(2'h1);
		n = 0;
		while (n < 2) begin
			`CHK({wmain, waux}, 2'h0, "early write")
			wend();
			if (last_seg == 3)
				n++;
		end
		`CHK({wmain, waux}, 2'h0, "early write")
		wend();
		`CHK({wmain, waux}, 2'h3, "write start")
		tend("record");
		u.send_mode(2'h0);
		wend_at(0);
		`CHK({wmain, waux, urd}, 3'h1, "record stop")
		flag_hold();
		tend("record exit");
		u.send_mode(2'h2);
		wend_at(2);
		`CHK(waux, 1'h0, "aux early")
		wend_at(0);
		`CHK({wmain, waux}, 2'h1, "aux start")
		u.send_mode(2'h1);
		u.send_mode(2'h0);
		wend_at(0);
		`CHK({waux, aexp}, 2'h0, "aux stop")
		for (int i = 1; i <= 5; i++) begin
			wend();
			`CHK(aexp, i == 3 || i == 4, "aux read window")
		end
		tend("aux record");
		// Start right after an end so no end is missed
		wend();
		u.search_enter();
		u.search_leave();
		`CHK(urd, 1'h1, "resync flag")
		flag_hold();
		tend("search");
		for (int i = 0; i < 12; i++) begin
			q = (i == 0) ? 2 : $urandom % 4;
			p = $urandom % 6;
			c = (q == 0) ? 1 + $urandom % 7 : $urandom % 8;
			r = (i == 0) ? 255 : (q == 0) ? $urandom % 64 : $urandom % 448;
			u.load_addr(2'(q), 3'(p), 3'(c), 9'(r));
			cpe = p * 16 + c * 2 + ((q == 0) ? 1 : r / 256);
			rbe = (q == 0) ? 128 + r : r % 256;
			`CHK({cp, rb}, {7'(cpe), 8'(rbe)}, "load map")
			u.inc_row();
			v = (cpe % 2) * 256 + rbe + 1;
			if (q == 0) begin
				rbe = 128 + (rbe + 1) % 128;
			end else begin
				cpe = cpe - cpe % 2 + (v % 512) / 256;
				rbe = v % 256;
			end
			`CHK({cp, rb}, {7'(cpe), 8'(rbe)}, "increment map")
		end
		tend("scratch");
		u.send_mode(2'h1);
		// Freeze outlasts a segment so a running timer would show against the model
		@(posedge ref_clk_in);
		ce_in <= 1'h0;
		n = 17 + $urandom % 8;
		repeat (n) begin
			@(negedge ref_clk_in);
			`CHK({wmain, waux, urd, aexp, cp, rb}, {4'h0, 7'(cpe), 8'(rbe)}, "freeze")
		end
		@(posedge ref_clk_in);
		ce_in <= 1'h1;
		wend();
		tend("freeze");
		stop_test();
	end
endmodule // testbench
`default_nettype wire
